/* rtl/dpg_cfg.svh */
// Purpose: Constants for the dual-port DRAM grant logic.
// Assumes: One 10 MHz core clock.
// Notes: Times are in nanoseconds; cycle counts derive from them.
`ifndef DPG_CFG_SVH
`define DPG_CFG_SVH
`define DPG_CLK_PERIOD_NS 100
`define DPG_RAS_LOW_NS 300
`define DPG_RAS_CYCLES ((`DPG_RAS_LOW_NS + `DPG_CLK_PERIOD_NS - 1) / `DPG_CLK_PERIOD_NS)
`define DPG_PRECHG_NS 200
`define DPG_PRECHG_CYCLES ((`DPG_PRECHG_NS + `DPG_CLK_PERIOD_NS - 1) / `DPG_CLK_PERIOD_NS)
`define DPG_GRANT_RESET 1'b0
`endif

/* rtl/dpg_pkg.sv */
// Purpose: Types for the dual-port DRAM grant logic.
// Assumes: Address widths fixed at eleven row, eleven column, two bank bits.
// Notes: Shared by the grant logic and the testbench; the timer does not use it.
package dpg_pkg;
  typedef struct packed {
    logic [10:0] row;
    logic [10:0] col;
    logic [1:0] bank;
  } dpg_addr_type;
  typedef enum logic [1:0] {
    DPG_IDLE,
    DPG_ACCESS,
    DPG_PRECHG
  } dpg_state_type;
  typedef enum logic [1:0] {
    DPG_OWNER_NONE,
    DPG_OWNER_A,
    DPG_OWNER_B,
    DPG_OWNER_REF
  } dpg_owner_type;
endpackage

/* rtl/dpg_timer.sv */
// Purpose: Down counter timing the strobe-low and precharge phases.
// Assumes: Load and count are synchronous to core_clk.
// Notes: done is high in the cycle the count reaches one.
`timescale 1ns/1ps
`default_nettype none
module dpg_timer #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign done = (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

/* rtl/dpg_grant.sv */
// Purpose: Second-port grant, strobe and early acknowledge of a dual-port DRAM controller.
// Assumes: All requests synchronous to core_clk; rst_n synchronous, active low.
// Notes: Second-port strobe is registered one cycle after the request edge when the array is free.
//
// Notes on behaviour
// - Second-port request captures row, column and bank and books a pending access.
// - Free array: second-port strobe asserts at the first possible moment.
// - Busy array: strobe asserts from a later rising clock edge when free.
// - Early acknowledge asserts together with the second-port strobe.
// - Grant high means second port owns array, low means first port.
// - Held lock by the granted port stalls the other port until released.
`timescale 1ns/1ps
`default_nettype none
`include "dpg_cfg.svh"
module dpg_grant #(
  parameter int RAS_CYCLES = `DPG_RAS_CYCLES,
  parameter int PRECHG_CYCLES = `DPG_PRECHG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic second_port_request,
  input wire dpg_pkg::dpg_addr_type second_addr,
  input wire logic first_port_request,
  input wire logic refresh_request,
  input wire logic lock,
  output logic second_port_owns_array,
  output logic second_port_early_ack,
  output logic ras_active,
  output logic first_port_ack,
  output logic refresh_ack,
  output dpg_pkg::dpg_addr_type latched_addr
);
  // ---------------------------------------------------------------
  // Request capture
  // ---------------------------------------------------------------
  logic pend_b_r;
  logic take_b;
  logic take_a;
  logic take_r;
  dpg_pkg::dpg_state_type state_r;
  dpg_pkg::dpg_owner_type owner_r;
  logic timer_done;
  logic timer_load;
  logic [3:0] timer_val;
  logic req_b_d_r;
  logic b_edge;

  assign b_edge = second_port_request && !req_b_d_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_b_d_r <= 1'b0;
    end else begin
      req_b_d_r <= second_port_request;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latched_addr <= '0;
    end else if (b_edge) begin
      latched_addr <= second_addr;
    end
  end

  // An edge that is served in its own cycle is not booked a second time.
  // A request raised again while one is pending still counts as one access.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pend_b_r <= 1'b0;
    end else if (b_edge && !take_b) begin
      pend_b_r <= 1'b1;
    end else if (take_b) begin
      pend_b_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  logic lock_held_r;
  logic b_ready;
  logic a_ready;
  assign b_ready = pend_b_r || b_edge;
  assign a_ready = first_port_request && !(lock_held_r && second_port_owns_array);
  // Refresh first unless a lock is held, then the port holding the grant, so a pending lock is honoured.
  always_comb begin
    take_r = 1'b0;
    take_a = 1'b0;
    take_b = 1'b0;
    if (state_r == dpg_pkg::DPG_IDLE) begin
      if (refresh_request && !lock_held_r) begin
        take_r = 1'b1;
      end else if (second_port_owns_array && b_ready) begin
        take_b = 1'b1;
      end else if (a_ready && !(lock_held_r && second_port_owns_array)) begin
        take_a = 1'b1;
      end else if (b_ready && !(lock_held_r && !second_port_owns_array)) begin
        take_b = 1'b1;
      end
    end
  end

  // Lock is sampled from the port that holds the grant during its own accesses; in idle a dropped lock only clears.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_held_r <= 1'b0;
    end else if (state_r != dpg_pkg::DPG_IDLE && owner_r != dpg_pkg::DPG_OWNER_REF) begin
      lock_held_r <= lock;
    end else if (state_r == dpg_pkg::DPG_IDLE && !lock) begin
      lock_held_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  always_comb begin
    timer_load = 1'b0;
    timer_val = 4'h0;
    if (take_a || take_b || take_r) begin
      timer_load = 1'b1;
      timer_val = 4'(RAS_CYCLES);
    end else if (state_r == dpg_pkg::DPG_ACCESS && timer_done) begin
      timer_load = 1'b1;
      timer_val = 4'(PRECHG_CYCLES);
    end
  end

  dpg_timer #(.WIDTH(4)) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_val(timer_val),
    .done(timer_done)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= dpg_pkg::DPG_IDLE;
    end else begin
      unique case (state_r)
        dpg_pkg::DPG_IDLE: begin
          if (take_a || take_b || take_r) begin
            state_r <= dpg_pkg::DPG_ACCESS;
          end
        end
        dpg_pkg::DPG_ACCESS: begin
          if (timer_done) begin
            state_r <= dpg_pkg::DPG_PRECHG;
          end
        end
        dpg_pkg::DPG_PRECHG: begin
          if (timer_done) begin
            state_r <= dpg_pkg::DPG_IDLE;
          end
        end
        default: begin
          state_r <= dpg_pkg::DPG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      owner_r <= dpg_pkg::DPG_OWNER_NONE;
    end else if (take_r) begin
      owner_r <= dpg_pkg::DPG_OWNER_REF;
    end else if (take_a) begin
      owner_r <= dpg_pkg::DPG_OWNER_A;
    end else if (take_b) begin
      owner_r <= dpg_pkg::DPG_OWNER_B;
    end
  end

  // Grant moves only at the start of a new access, from idle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      second_port_owns_array <= `DPG_GRANT_RESET;
    end else if (take_b) begin
      second_port_owns_array <= 1'b1;
    end else if (take_a) begin
      second_port_owns_array <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Strobe and acknowledge outputs
  // ---------------------------------------------------------------
  logic strobe_nxt;
  assign strobe_nxt = (take_a || take_b || take_r) ||
                      (state_r == dpg_pkg::DPG_ACCESS && !timer_done);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ras_active <= 1'b0;
      second_port_early_ack <= 1'b0;
      first_port_ack <= 1'b0;
      refresh_ack <= 1'b0;
    end else begin
      ras_active <= strobe_nxt;
      second_port_early_ack <= take_b ||
        (strobe_nxt && !take_a && !take_r && owner_r == dpg_pkg::DPG_OWNER_B);
      first_port_ack <= take_a;
      refresh_ack <= take_r;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_capture;
    @(posedge core_clk) disable iff (!rst_n)
      b_edge |=> (latched_addr == $past(second_addr)) && (pend_b_r == !$past(take_b));
  endproperty
  a_capture: assert property (p_capture) else $error("address not captured");

  property p_free_start;
    @(posedge core_clk) disable iff (!rst_n)
      (b_edge && state_r == dpg_pkg::DPG_IDLE && !refresh_request && !lock_held_r &&
       !first_port_request) |=> ras_active && second_port_early_ack;
  endproperty
  a_free_start: assert property (p_free_start) else $error("free access not started");

  property p_busy_wait;
    @(posedge core_clk) disable iff (!rst_n)
      (pend_b_r && state_r == dpg_pkg::DPG_PRECHG && !lock_held_r && !refresh_request &&
       !first_port_request) |-> ##[1:12] second_port_early_ack;
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("delayed access never served");

  property p_ack_with_ras;
    @(posedge core_clk) disable iff (!rst_n)
      second_port_early_ack |-> ras_active && second_port_owns_array;
  endproperty
  a_ack_with_ras: assert property (p_ack_with_ras) else $error("ack without strobe");

  property p_grant_meaning;
    @(posedge core_clk) disable iff (!rst_n)
      first_port_ack |-> !second_port_owns_array;
  endproperty
  a_grant_meaning: assert property (p_grant_meaning) else $error("grant wrong for first port");

  property p_lock_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (lock_held_r && second_port_owns_array) |=> !first_port_ack;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock not honoured");

  property p_grant_stable;
    @(posedge core_clk) disable iff (!rst_n)
      (ras_active && $past(ras_active)) |-> $stable(second_port_owns_array);
  endproperty
  a_grant_stable: assert property (p_grant_stable) else $error("grant moved mid access");

  property p_one_at_a_time;
    @(posedge core_clk) disable iff (!rst_n)
      $onehot0({first_port_ack, refresh_ack, second_port_early_ack && $rose(ras_active)});
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time) else $error("two accesses at once");

  c_b_access: cover property (@(posedge core_clk) disable iff (!rst_n)
    b_edge ##1 second_port_early_ack);
  c_a_access: cover property (@(posedge core_clk) disable iff (!rst_n) first_port_ack);
  c_refresh: cover property (@(posedge core_clk) disable iff (!rst_n) refresh_ack);
  c_locked: cover property (@(posedge core_clk) disable iff (!rst_n)
    lock_held_r && first_port_request && second_port_owns_array);
endmodule
`default_nettype wire

/* testbench/dpg_far_port.sv */
// Purpose: Model of the second processor that requests DRAM accesses.
// Assumes: Requests move 1 ns after the core_clk rising edge.
// Notes: Address lines read inverted once the request is withdrawn.
`timescale 1ns/1ps
`default_nettype none
module dpg_far_port (
  input wire logic core_clk,
  input wire logic go,
  input wire dpg_pkg::dpg_addr_type addr_in,
  input wire logic lock_a,
  input wire logic lock_b,
  input wire logic grant,
  input wire logic early_ack,
  output logic request,
  output dpg_pkg::dpg_addr_type addr,
  output logic lock,
  output logic transfer_ack_out
);
  initial begin
    request = 1'b0;
    addr = 24'h00_0000;
  end
  // The request and address move after an edge and hold until acknowledged.
  always @(posedge core_clk) begin
    if (request && early_ack) begin
      #1 request = 1'b0;
      addr = ~addr;
    end else if (!request && go) begin
      #1 request = 1'b1;
      addr = addr_in;
    end
  end
  assign transfer_ack_out = request & early_ack;
  assign lock = grant ? lock_b : lock_a;
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the second-port grant logic.
// Assumes: Inputs driven 1 ns after each rising edge.
// Notes: The far port model owns the second-port request and address.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int RAS = 3;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic first_port_request = 1'b0;
  logic refresh_request = 1'b0;
  logic lock_a = 1'b0;
  logic lock_b = 1'b0;
  logic req, lock, grant, early_ack, ras_active, first_port_ack, refresh_ack, xfer_ack;
  dpg_pkg::dpg_addr_type addr_in = 24'h00_0000;
  dpg_pkg::dpg_addr_type b_addr, latched_addr;
  int fails = 0;
  int samples_checked = 0;
  int n;

  always #50 core_clk = ~core_clk;

  dpg_far_port far (.core_clk(core_clk), .go(go), .addr_in(addr_in), .lock_a(lock_a),
    .lock_b(lock_b), .grant(grant), .early_ack(early_ack), .request(req), .addr(b_addr),
    .lock(lock), .transfer_ack_out(xfer_ack));

  dpg_grant #(.RAS_CYCLES(RAS), .PRECHG_CYCLES(2)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .second_port_request(req), .second_addr(b_addr), .first_port_request(first_port_request),
    .refresh_request(refresh_request), .lock(lock), .second_port_owns_array(grant),
    .second_port_early_ack(early_ack), .ras_active(ras_active),
    .first_port_ack(first_port_ack), .refresh_ack(refresh_ack), .latched_addr(latched_addr));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic stop_test();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Runs one second-port access and returns the cycles until early acknowledge.
  task automatic b_access(input logic [23:0] a, input logic with_a, output int w);
    addr_in = a;
    go = 1'b1;
    first_port_request = with_a;
    step(1);
    go = 1'b0;
    first_port_request = 1'b0;
    w = 0;
    while (early_ack !== 1'b1 && w < 60) begin
      step(1);
      w++;
    end
    chk(latched_addr, a);
    chk(xfer_ack, 1'b1);
    for (int k = 0; k < RAS + 1; k++) begin
      chk(ras_active, k < RAS);
      chk(early_ack, k < RAS);
      chk(grant, 1'b1);
      step(1);
    end
    step(2);
  endtask

  task automatic a_access();
    first_port_request = 1'b1;
    step(1);
    first_port_request = 1'b0;
    chk({first_port_ack, ras_active, grant, early_ack}, 4'hc);
    step(1);
    chk(first_port_ack, 1'b0);
    step(6);
  endtask

  task automatic refresh(input logic g);
    refresh_request = 1'b1;
    step(1);
    refresh_request = 1'b0;
    chk({refresh_ack, ras_active, grant}, {2'h3, g});
    step(1);
    chk(refresh_ack, 1'b0);
    step(6);
  endtask

  // The second port holds lock; a first-port request must wait until it drops.
  task automatic b_lock_access();
    int w;
    lock_b = 1'b1;
    b_access(24'h3c_3c3c, 1'b0, w);
    chk(w, 1);
    first_port_request = 1'b1;
    step(8);
    chk({first_port_ack, ras_active, grant}, 3'h1);
    lock_b = 1'b0;
    w = 0;
    while (first_port_ack !== 1'b1 && w < 20) begin
      step(1);
      w++;
    end
    first_port_request = 1'b0;
    chk({first_port_ack, grant}, 2'h2);
    chk(w, 2);
    step(7);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(16);
    chk({grant, early_ack, ras_active, first_port_ack, refresh_ack}, 5'h00);
    rst_n = 1'b1;
    step(1);
    b_access(24'hab_cdef, 1'b0, n);
    chk(n, 1);
    b_access(24'h54_3210, 1'b0, n);
    chk(n, 1);
    refresh(1'b1);
    a_access();
    refresh(1'b0);
    b_access(24'h12_3456, 1'b1, n);
    chk(n >= 5 && n <= 9, 1'b1);
    a_access();
    lock_a = 1'b1;
    a_access();
    fork
      b_access(24'h0f_0f0f, 1'b0, n);
      begin
        step(20);
        lock_a = 1'b0;
      end
    join
    chk(n >= 20 && n <= 24, 1'b1);
    b_lock_access();
    stop_test();
  end

  initial begin
    #(100 * 3000);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
